// ===== design/etpc_timer.sv
// Notes on behaviour
// - edge PWM, clear-select 0: period match clears counter
// - clear-select 1: A match clears, B sets duty
// - alignment field 11 gives centre-aligned PWM
// - counting continues while outputs forced 00/01
// - centre PWM: period flag at down-count zero
// - run rising edge starts counter and pulse A
// - comparator B match starts pulse B
// - single pulse: trigger pin edge sets run bit
// - run clear or A match ends both pulses
// - single pulse: counter zeroed only on run rise
// - single pulse: A and B matches flag
// - capture edge rising, falling or both per io
// - selected edge latches counter, raises flag
// - capture counter free-runs until run falls
// - capture: period match zeroes counter and flags
// - period value zero runs full count range
// - io 11 in capture: no capture, counter runs
// - capture ignores clear/init/polarity; pin left undriven
`timescale 1ns/100ps
`default_nettype none

module etpc_timer
	import etpc_pkg::*;
#(
	parameter int CNT_W  = ETPC_CNT_W,
	parameter int PERIOD_COMPARE_VALUE_W = ETPC_PERIOD_COMPARE_VALUE_W
) (
	input  wire logic              clock,                // system clock
	input  wire logic              sys_rst,              // sync reset
	input  wire logic              count_tick,           // timer clock enable
	input  wire etpc_chan_ctrl_s   timer_control_one,    // channel a ctrl
	input  wire etpc_chan_ctrl_s   timer_control_two,    // channel b ctrl
	input  wire logic              counter_clear_select, // period source
	input  wire logic [1:0]        pwm_alignment_field,  // pwm alignment
	input  wire logic [PERIOD_COMPARE_VALUE_W-1:0] period_compare_value, // period compare
	input  wire logic              run_write,            // run bit write
	input  wire logic              run_wdata,            // run bit value
	input  wire logic              compare_a_value_write,           // compare a write
	input  wire logic              compare_b_value_write,           // compare b write
	input  wire logic [CNT_W-1:0]  ccr_wdata,            // compare wr data
	input  wire logic              trigger_falling,      // trigger edge sel
	input  wire logic              pin_a_enable,         // pin a as output
	input  wire logic              pin_b_enable,         // pin b as output
	input  wire logic [1:0]        pin_b_select,         // pin b option
	input  wire logic              external_trigger_pin, // trigger pin
	input  wire logic              timer_pin_a_in,       // pin a level
	output var  logic              timer_pin_a_out,      // pin a drive
	output var  logic              timer_pin_a_oe,       // pin a enable
	input  wire logic [2:0]        timer_pin_b_in,       // pin b levels
	output var  logic [2:0]        timer_pin_b_out,      // pin b drives
	output var  logic [2:0]        timer_pin_b_oe,       // pin b enables
	output var  logic              counter_run_bit,      // run bit
	output var  logic [CNT_W-1:0]  compare_a_value,      // compare a reg
	output var  logic [CNT_W-1:0]  compare_b_value,      // compare b reg
	output var  logic [CNT_W-1:0]  counter_value,        // live counter
	output var  logic              flag_a,               // a event pulse
	output var  logic              flag_b,               // b event pulse
	output var  logic              flag_p                // period pulse
);

	// ------------------------------------------------------------
	// pin synchronisers
	// ------------------------------------------------------------
	logic [ETPC_SYNC_W-1:0] pin_rise;
	logic [ETPC_SYNC_W-1:0] pin_fall;

	// pins are sampled as seen on the pad, own drive included
	etpc_sync_edge #(
		.WIDTH (ETPC_SYNC_W)
	) u_sync (
		.clock    (clock),
		.sys_rst  (sys_rst),
		.async_in ({external_trigger_pin, timer_pin_b_in, timer_pin_a_in}),
		.rise     (pin_rise),
		.fall     (pin_fall)
	);

	// ------------------------------------------------------------
	// declarations
	// ------------------------------------------------------------
	logic                 run_reg, run_q_reg, down_reg, down_next;
	logic                 flag_p_reg, flag_p_next, pin_a_oe_reg;
	logic [2:0]           pin_b_oe_reg, b_onehot;
	logic [CNT_W-1:0]     cnt_reg, cnt_next;
	etpc_chan_ctrl_s      ctrl [ETPC_CHANNELS];
	logic [CNT_W-1:0]     ccr_reg [ETPC_CHANNELS];
	logic [1:0]           cap_hit, cmp_hit, ccr_wr, sp_start, pin_en;
	logic [1:0]           chan_rise, chan_fall, chan_out, oe_next, flag_bits;
	logic                 b_rise, b_fall, run_rise, tick_run, trig_set;
	logic                 a_stop, sp_mode, cap_mode, pwm_mode, centre;
	logic                 period_compare_value_zero, top_hit, cnt_zero, c_top_zero;
	logic [CNT_W-1:0]     p_top, c_top, e_top, top_sel;

	assign ctrl[0] = timer_control_one;
	assign ctrl[1] = timer_control_two;
	assign ccr_wr  = {compare_b_value_write, compare_a_value_write};
	assign pin_en  = {pin_b_enable, pin_a_enable};

	// ------------------------------------------------------------
	// mode decode
	// ------------------------------------------------------------
	assign sp_mode  = (ctrl[0].mode == ETPC_MODE_PULSE)
		&& (ctrl[0].io == ETPC_IO_SINGLE);
	assign cap_mode = ctrl[0].mode == ETPC_MODE_CAPTURE;
	assign pwm_mode = (ctrl[0].mode == ETPC_MODE_PULSE) && !sp_mode;
	assign centre   = pwm_mode
		&& (pwm_alignment_field == ETPC_ALIGN_CENTRE);

	// ------------------------------------------------------------
	// pin b option select
	// ------------------------------------------------------------
	assign b_rise = (pin_b_select == ETPC_PIN_B_SEL2)
		? pin_rise[ETPC_SYNC_PIN_B2]
		: (pin_b_select == ETPC_PIN_B_SEL1) ? pin_rise[ETPC_SYNC_PIN_B1]
		: pin_rise[ETPC_SYNC_PIN_B0];
	assign b_fall = (pin_b_select == ETPC_PIN_B_SEL2)
		? pin_fall[ETPC_SYNC_PIN_B2]
		: (pin_b_select == ETPC_PIN_B_SEL1) ? pin_fall[ETPC_SYNC_PIN_B1]
		: pin_fall[ETPC_SYNC_PIN_B0];
	assign b_onehot = (pin_b_select == ETPC_PIN_B_SEL2) ? 3'h4
		: (pin_b_select == ETPC_PIN_B_SEL1) ? 3'h2 : 3'h1;
	assign chan_rise = {b_rise, pin_rise[ETPC_SYNC_PIN_A]};
	assign chan_fall = {b_fall, pin_fall[ETPC_SYNC_PIN_A]};

	// ------------------------------------------------------------
	// run bit
	// ------------------------------------------------------------
	assign run_rise = run_reg & ~run_q_reg;
	assign trig_set = sp_mode & (trigger_falling
		? pin_fall[ETPC_SYNC_TRIG] : pin_rise[ETPC_SYNC_TRIG]);
	assign a_stop   = sp_mode & cmp_hit[0];

	// trigger set wins over any clear in the same cycle
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			run_reg   <= ETPC_RUN_RST;
			run_q_reg <= ETPC_RUN_RST;
		end else begin
			run_q_reg <= run_reg;
			if (trig_set) begin
				run_reg <= 1'h1;
			end else if (run_write) begin
				run_reg <= run_wdata;
			end else if (a_stop) begin
				run_reg <= 1'h0;
			end
		end
	end

	// ------------------------------------------------------------
	// counter limits
	// ------------------------------------------------------------
	assign period_compare_value_zero  = period_compare_value == '0;
	// zero period value lets the counter run its whole range
	assign p_top = period_compare_value_zero ? '1 : CNT_W'({period_compare_value,
		ETPC_PERIOD_SHIFT'(0)} - 1);
	assign c_top = counter_clear_select ? ccr_reg[0] : period_compare_value_zero ? '1
		: CNT_W'({period_compare_value, ETPC_PERIOD_SHIFT'(0)});
	assign e_top = !counter_clear_select ? p_top
		: pwm_mode ? CNT_W'(ccr_reg[0] - 1'h1) : ccr_reg[0];
	// capture ignores the clear select
	assign top_sel    = centre ? c_top : cap_mode ? p_top : e_top;
	assign top_hit    = cnt_reg == top_sel;
	assign cnt_zero   = cnt_reg == '0;
	assign c_top_zero = c_top == '0;

	// ------------------------------------------------------------
	// counter next state
	// ------------------------------------------------------------
	// counting depends on the output control fields only through io 11 (single pulse)
	assign tick_run = count_tick & run_reg & ~run_rise;

	always_comb begin
		cnt_next  = cnt_reg;
		down_next = down_reg;
		if (sp_mode) begin
			cnt_next = CNT_W'(cnt_reg + 1'h1);
		end else if (centre) begin
			if (c_top_zero) begin
				cnt_next = '0;
			end else if (!down_reg && top_hit) begin
				cnt_next  = CNT_W'(cnt_reg - 1'h1);
				down_next = 1'h1;
			end else if (down_reg && cnt_zero) begin
				cnt_next  = CNT_W'(cnt_reg + 1'h1);
				down_next = 1'h0;
			end else if (down_reg) begin
				cnt_next = CNT_W'(cnt_reg - 1'h1);
			end else begin
				cnt_next = CNT_W'(cnt_reg + 1'h1);
			end
		end else begin
			cnt_next = top_hit ? '0 : CNT_W'(cnt_reg + 1'h1);
			down_next = 1'h0;
		end
	end

	// period flag: centre at down-count zero, else at the period top (not in single pulse; with clear select 1, capture only)
	// a top of one turns at 1 and falls to zero without a down phase
	assign flag_p_next = tick_run & (centre
		? ((down_reg | top_hit) & (cnt_reg == CNT_W'(1))
			& !c_top_zero)
		: (!sp_mode && top_hit
			&& (cap_mode || !counter_clear_select)));

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cnt_reg  <= '0;
			down_reg <= 1'h0;
		end else if (run_rise) begin
			cnt_reg  <= '0;
			down_reg <= 1'h0;
		end else if (tick_run) begin
			cnt_reg  <= cnt_next;
			down_reg <= down_next;
		end
	end

	// ------------------------------------------------------------
	// per channel compare, capture and output
	// ------------------------------------------------------------
	assign sp_start = {cmp_hit[1], run_rise};

	for (genvar i = 0; i < ETPC_CHANNELS; i++) begin : g_chan
		logic [CNT_W-1:0] ccr_q;
		logic             state_q, sp_on_q, out_q, flag_q;
		logic             mode_cap, mode_cmp, mode_pls, edge_hit;
		logic             pwm_lvl, cmp_lvl, raw;

		assign mode_cap = ctrl[i].mode == ETPC_MODE_CAPTURE;
		assign mode_cmp = ctrl[i].mode == ETPC_MODE_COMPARE;
		assign mode_pls = ctrl[i].mode == ETPC_MODE_PULSE;
		assign edge_hit = ((ctrl[i].io == ETPC_EDGE_RISE) & chan_rise[i])
			| ((ctrl[i].io == ETPC_EDGE_FALL) & chan_fall[i])
			| ((ctrl[i].io == ETPC_EDGE_BOTH)
				& (chan_rise[i] | chan_fall[i]));
		assign cap_hit[i] = mode_cap & edge_hit;
		assign cmp_hit[i] = tick_run & ~mode_cap
			& (cnt_reg == ccr_q);

		// duty compare holds across up and down counting
		assign pwm_lvl = (cnt_reg < ccr_q)
			? ctrl[i].init_state : ~ctrl[i].init_state;
		assign cmp_lvl = (ctrl[i].io == ETPC_CMP_LOW) ? 1'h0
			: (ctrl[i].io == ETPC_CMP_HIGH) ? 1'h1
			: (ctrl[i].io == ETPC_CMP_TOGGLE) ? ~state_q : state_q;
		assign raw = sp_mode ? sp_on_q
			: !mode_pls ? state_q
			: (ctrl[i].io == ETPC_IO_FORCE_LOW) ? 1'h0
			: (ctrl[i].io == ETPC_IO_FORCE_HIGH) ? 1'h1
			: pwm_lvl;
		// capture and timer modes leave the pin undriven
		assign oe_next[i] = pin_en[i] & (mode_cmp | mode_pls);

		// capture wins over a software write in the same cycle
		always_ff @(posedge clock) begin
			if (sys_rst) begin
				ccr_q <= '0;
			end else if (cap_hit[i]) begin
				ccr_q <= cnt_reg;
			end else if (ccr_wr[i]) begin
				ccr_q <= ccr_wdata;
			end
		end

		always_ff @(posedge clock) begin
			if (sys_rst) begin
				state_q <= ETPC_PIN_RST;
			end else if (run_rise) begin
				state_q <= ctrl[i].init_state;
			end else if (cmp_hit[i] && mode_cmp) begin
				state_q <= cmp_lvl;
			end
		end

		// pulse ends whenever the run bit drops
		always_ff @(posedge clock) begin
			if (sys_rst || !run_reg) begin
				sp_on_q <= 1'h0;
			end else if (sp_start[i]) begin
				sp_on_q <= 1'h1;
			end
		end

		always_ff @(posedge clock) begin
			if (sys_rst) begin
				out_q  <= ETPC_PIN_RST;
				flag_q <= ETPC_FLAG_RST;
			end else begin
				out_q  <= raw ^ ctrl[i].polarity;
				flag_q <= cap_hit[i] | cmp_hit[i];
			end
		end

		assign ccr_reg[i]   = ccr_q;
		assign chan_out[i]  = out_q;
		assign flag_bits[i] = flag_q;
	end

	// ------------------------------------------------------------
	// enables and period flag
	// ------------------------------------------------------------
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			pin_a_oe_reg <= 1'h0;
			pin_b_oe_reg <= 3'h0;
			flag_p_reg   <= ETPC_FLAG_RST;
		end else begin
			pin_a_oe_reg <= oe_next[0];
			pin_b_oe_reg <= b_onehot & {3{oe_next[1]}};
			flag_p_reg   <= flag_p_next;
		end
	end

	// ------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------
	assign timer_pin_a_out = chan_out[0];
	assign timer_pin_a_oe  = pin_a_oe_reg;
	assign timer_pin_b_out = {3{chan_out[1]}};
	assign timer_pin_b_oe  = pin_b_oe_reg;
	assign counter_run_bit = run_reg;
	assign compare_a_value = ccr_reg[0];
	assign compare_b_value = ccr_reg[1];
	assign counter_value   = cnt_reg;
	assign flag_a          = flag_bits[0];
	assign flag_b          = flag_bits[1];
	assign flag_p          = flag_p_reg;

endmodule

`default_nettype wire

// ===== design/etpc_pkg.sv
`default_nettype none

package etpc_pkg;

	// ------------------------------------------------------------
	// widths and counter geometry
	// ------------------------------------------------------------
	localparam int ETPC_CNT_W        = 10;
	localparam int ETPC_PERIOD_COMPARE_VALUE_W       = 3;
	localparam int ETPC_PERIOD_SHIFT = 7;
	localparam int ETPC_CHANNELS     = 2;
	localparam int ETPC_PIN_B_COUNT  = 3;
	// synchroniser slots: pin a, pin b options 0..2, trigger pin
	localparam int ETPC_SYNC_W       = 5;
	localparam int ETPC_SYNC_PIN_A   = 0;
	localparam int ETPC_SYNC_PIN_B0  = 1;
	localparam int ETPC_SYNC_PIN_B1  = 2;
	localparam int ETPC_SYNC_PIN_B2  = 3;
	localparam int ETPC_SYNC_TRIG    = 4;

	// ------------------------------------------------------------
	// mode select field encodings
	// ------------------------------------------------------------
	localparam logic [1:0] ETPC_MODE_COMPARE = 2'h0;
	localparam logic [1:0] ETPC_MODE_CAPTURE = 2'h1;
	localparam logic [1:0] ETPC_MODE_PULSE   = 2'h2;
	localparam logic [1:0] ETPC_MODE_TIMER   = 2'h3;

	// ------------------------------------------------------------
	// output control field, read per mode
	// ------------------------------------------------------------
	localparam logic [1:0] ETPC_IO_FORCE_LOW  = 2'h0;
	localparam logic [1:0] ETPC_IO_FORCE_HIGH = 2'h1;
	localparam logic [1:0] ETPC_IO_PWM        = 2'h2;
	localparam logic [1:0] ETPC_IO_SINGLE     = 2'h3;
	localparam logic [1:0] ETPC_CMP_NONE      = 2'h0;
	localparam logic [1:0] ETPC_CMP_LOW       = 2'h1;
	localparam logic [1:0] ETPC_CMP_HIGH      = 2'h2;
	localparam logic [1:0] ETPC_CMP_TOGGLE    = 2'h3;
	localparam logic [1:0] ETPC_EDGE_RISE     = 2'h0;
	localparam logic [1:0] ETPC_EDGE_FALL     = 2'h1;
	localparam logic [1:0] ETPC_EDGE_BOTH     = 2'h2;
	localparam logic [1:0] ETPC_EDGE_NONE     = 2'h3;

	localparam logic [1:0] ETPC_ALIGN_CENTRE = 2'h3;
	localparam logic [1:0] ETPC_PIN_B_SEL1   = 2'h1;
	localparam logic [1:0] ETPC_PIN_B_SEL2   = 2'h2;

	// ------------------------------------------------------------
	// reset values
	// ------------------------------------------------------------
	localparam logic ETPC_RUN_RST  = 1'h0;
	localparam logic ETPC_PIN_RST  = 1'h0;
	localparam logic ETPC_FLAG_RST = 1'h0;

	// ------------------------------------------------------------
	// per-channel control bits
	// ------------------------------------------------------------
	typedef struct packed {
		logic [1:0] mode;
		logic [1:0] io;
		logic       init_state;
		logic       polarity;
	} etpc_chan_ctrl_s;

endpackage

`default_nettype wire

// ===== design/etpc_sync_edge.sv
`timescale 1ns/100ps
`default_nettype none

module etpc_sync_edge #(
	parameter int WIDTH = 1
) (
	input  wire logic             clock,    // system clock
	input  wire logic             sys_rst,  // synchronous reset
	input  wire logic [WIDTH-1:0] async_in, // pins from outside
	output var  logic [WIDTH-1:0] rise,     // one-cycle rising pulse
	output var  logic [WIDTH-1:0] fall      // one-cycle falling pulse
);

	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] stable_reg;
	logic [WIDTH-1:0] prev_reg;

	// chain tracks the pins in reset too, so a pin idling high
	// gives no false edge once reset is released
	always_ff @(posedge clock) begin
		meta_reg   <= async_in;
		stable_reg <= meta_reg;
		prev_reg   <= stable_reg;
	end

	assign rise = stable_reg & ~prev_reg & ~{WIDTH{sys_rst}};
	assign fall = ~stable_reg & prev_reg & ~{WIDTH{sys_rst}};

endmodule

`default_nettype wire

// ===== bench/etpc_pin_model.sv
`timescale 1ns/100ps
`default_nettype none

module etpc_pin_model (
	input	wire logic			a_lvl,	// far-side level a
	input	wire logic [2:0]	b_lvl,	// far-side levels b
	input	wire logic			a_out,	// timer drive a
	input	wire logic			a_oe,	// timer enable a
	input	wire logic [2:0]	b_out,	// timer drives b
	input	wire logic [2:0]	b_oe,	// timer enables b
	output	wire logic			a_pin,	// resolved pin a
	output	wire logic [2:0]	b_pin	// resolved pins b
);
	// timer drive wins, so the pin samples still see it
	assign a_pin = a_oe ? a_out : a_lvl;
	assign b_pin = (b_oe & b_out) | (~b_oe & b_lvl);
endmodule

`default_nettype wire

// ===== bench/etpc_timer_chk.sv
`timescale 1ns/100ps
`default_nettype none

module etpc_timer_chk
	import etpc_pkg::*;
#(
	parameter int CNT_W  = ETPC_CNT_W,
	parameter int PERIOD_COMPARE_VALUE_W = ETPC_PERIOD_COMPARE_VALUE_W
) (
	input	wire logic				clock,	// clock
	input	wire logic				sys_rst,	// reset
	input	wire logic				count_tick,	// count enable
	input	wire etpc_chan_ctrl_s	timer_control_one,	// channel a
	input	wire etpc_chan_ctrl_s	timer_control_two,	// channel b
	input	wire logic				counter_clear_select,	// period source
	input	wire logic [1:0]		pwm_alignment_field,	// alignment
	input	wire logic [PERIOD_COMPARE_VALUE_W-1:0]	period_compare_value,	// period
	input	wire logic				run_write,	// run write
	input	wire logic				run_wdata,	// run value
	input	wire logic				compare_b_value_write,	// compare b write
	input	wire logic [2:0]		timer_pin_b_out,	// pin b drive
	input	wire logic				counter_run_bit,	// run bit
	input	wire logic [CNT_W-1:0]	compare_a_value,	// compare a
	input	wire logic [CNT_W-1:0]	compare_b_value,	// compare b
	input	wire logic [CNT_W-1:0]	counter_value,	// counter
	input	wire logic				flag_a,	// a event
	input	wire logic				flag_b,	// b event
	input	wire logic				flag_p	// period event
);
	// ----------------------------------------
	// mode decode and expected counts
	// ----------------------------------------
	logic [CNT_W-1:0]	nxt_reg;
	logic				none_reg;
	wire logic	cap_a = timer_control_one.mode == ETPC_MODE_CAPTURE;
	wire logic	cap_b = timer_control_two.mode == ETPC_MODE_CAPTURE;
	wire logic	pls = timer_control_one.mode == ETPC_MODE_PULSE;
	wire logic	sp = pls && timer_control_one.io == ETPC_IO_SINGLE;
	wire logic	cen = pls && !sp
		&& pwm_alignment_field == ETPC_ALIGN_CENTRE;
	wire logic [CNT_W-1:0]	per =
		CNT_W'(period_compare_value) << ETPC_PERIOD_SHIFT;
	wire logic [CNT_W-1:0]	p_top = per == '0 ? '1 : per - 1'b1;
	wire logic [CNT_W-1:0]	c_top = counter_clear_select ? compare_a_value
		: (per == '0 ? '1 : per);

	always_ff @(posedge clock) begin
		nxt_reg <= counter_value == p_top ? '0 : counter_value + 1'b1;
		none_reg <= cap_b && timer_control_two.io == ETPC_EDGE_NONE;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (sys_rst);

	AST_RUN_SET: assert property (
		run_write && run_wdata |=> counter_run_bit)
		else $error("run bit not set by write");
	AST_RUN_ZERO: assert property (
		$rose(counter_run_bit) |=> counter_value == '0)
		else $error("counter not zeroed on run rise");
	AST_SP_END: assert property (
		sp && $rose(flag_a) && !run_write |-> ##[0:2] !counter_run_bit)
		else $error("a match left run bit set");
	AST_SP_PIN_B: assert property (
		sp && $rose(flag_b) && counter_run_bit
		|-> ##[0:3] timer_pin_b_out[0] == !timer_control_two.polarity)
		else $error("pin b pulse missing");
	AST_CAP_CNT: assert property (
		cap_a && counter_run_bit && $past(counter_run_bit) && !run_write
		&& count_tick |=> counter_value == nxt_reg)
		else $error("capture counter step wrong");
	AST_CAP_NONE: assert property (
		none_reg && cap_b && timer_control_two.io == ETPC_EDGE_NONE
		&& !$past(compare_b_value_write) |-> $stable(compare_b_value))
		else $error("capture with edge select none");
	AST_CEN_TOP: assert property (
		cen && counter_run_bit && $past(counter_run_bit)
		|-> counter_value <= c_top)
		else $error("centre counter above top");
	AST_CEN_PER: assert property (
		cen && counter_run_bit && $past(counter_run_bit)
		&& $past(counter_run_bit, 2) && $past(counter_value) == 1
		&& counter_value == 0 |-> ##[0:1] flag_p)
		else $error("no period event at zero");

	cover property (cap_a && flag_a);
	cover property (sp && flag_b);
	cover property (cen && flag_p);
endmodule

bind etpc_timer etpc_timer_chk #(
	.CNT_W (CNT_W),
	.PERIOD_COMPARE_VALUE_W(PERIOD_COMPARE_VALUE_W)
) etpc_timer_chk_i (.*);

`default_nettype wire

// ===== bench/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top
	import etpc_pkg::*;
;
	logic				clock = 1'h0;
	logic				sys_rst = 1'h1;
	logic				count_tick = 1'h0;
	etpc_chan_ctrl_s	timer_control_one = '0;
	etpc_chan_ctrl_s	timer_control_two = '0;
	logic				counter_clear_select = 1'h0;
	logic				run_write = 1'h0;
	logic				run_wdata = 1'h0;
	logic				compare_a_value_write = 1'h0;
	logic				compare_b_value_write = 1'h0;
	logic				trigger_falling = 1'h0;
	logic				pin_a_enable = 1'h0;
	logic				pin_b_enable = 1'h0;
	logic				external_trigger_pin = 1'h0;
	logic				a_lvl = 1'h0;
	logic [1:0]			pwm_alignment_field = 2'h0;
	logic [1:0]			pin_b_select = 2'h0;
	logic [2:0]			period_compare_value = 3'h0;
	logic [2:0]			b_lvl = 3'h0;
	logic [9:0]			ccr_wdata = 10'h000;
	logic				timer_pin_a_in, timer_pin_a_out, timer_pin_a_oe;
	logic				counter_run_bit, flag_a, flag_b, flag_p;
	logic [2:0]			timer_pin_b_in, timer_pin_b_out, timer_pin_b_oe;
	logic [9:0]			compare_a_value, compare_b_value, counter_value;
	int					n_fail = 0, total_checks = 0, n_fa, n_fb, n_fp;
	wire logic [3:0]	pin_oe = {timer_pin_a_oe, timer_pin_b_oe};

	always #5 clock = ~clock;

	etpc_timer etpc_timer_i (.*);
	etpc_pin_model etpc_pin_model_i (
		.a_lvl(a_lvl), .b_lvl(b_lvl), .a_out(timer_pin_a_out),
		.a_oe(timer_pin_a_oe), .b_out(timer_pin_b_out), .b_oe(timer_pin_b_oe),
		.a_pin(timer_pin_a_in), .b_pin(timer_pin_b_in)
	);

	// ----------------------------------------
	// access tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [15:0] seen, exp);
		total_checks++;
		if (seen !== exp) begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic idle(input int n);
		repeat (n) begin
			@(posedge clock);
			n_fa += (flag_a === 1'h1);
			n_fb += (flag_b === 1'h1);
			n_fp += (flag_p === 1'h1);
		end
	endtask

	task automatic tk(input int n);
		repeat (n) begin
			count_tick <= 1'h1;
			idle(1);
			count_tick <= 1'h0;
			idle(4);
		end
	endtask

	task automatic wr_run(input logic v);
		run_write <= 1'h1;
		run_wdata <= v;
		idle(1);
		run_write <= 1'h0;
		idle(5);
	endtask

	task automatic wr_cc(input logic b, input logic [9:0] d);
		compare_a_value_write <= !b;
		compare_b_value_write <= b;
		ccr_wdata <= d;
		idle(1);
		compare_a_value_write <= 1'h0;
		compare_b_value_write <= 1'h0;
		idle(2);
	endtask

	task automatic cfg(input logic [1:0] m, ia, ib);
		timer_control_one <= '{m, ia, 1'h0, 1'h0};
		timer_control_two <= '{m, ib, 1'h0, 1'h0};
		idle(2);
	endtask

	task automatic stop_test;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// ----------------------------------------
	// sequence
	// ----------------------------------------
	initial begin
		int c, e_b, top;
		repeat (20) @(posedge clock);
		sys_rst <= 1'h0;
		idle(1);
		chk("run", counter_run_bit, 1'h0);
		chk("cnt", counter_value, 10'h000);
		counter_clear_select <= 1'h1;
		pin_a_enable <= 1'h1;
		pin_b_enable <= 1'h1;
		cfg(ETPC_MODE_CAPTURE, ETPC_EDGE_RISE, ETPC_EDGE_RISE);
		wr_run(1'h1);
		n_fa = 0;
		tk(5);
		a_lvl <= 1'h1;
		idle(6);
		chk("cap_a", compare_a_value, 10'h005);
		chk("flag_a", n_fa, 16'h0001);
		chk("cap_oe", pin_oe, 4'h0);
		tk(2);
		a_lvl <= 1'h0;
		idle(6);
		chk("cap_a_fall", compare_a_value, 10'h005);
		c = 7;
		e_b = 0;
		for (int k = 0; k < 4; k++) begin
			pin_b_select <= 2'(k);
			timer_control_two.io <= 2'(k);
			for (int e = 0; e < 2; e++) begin
				tk(1);
				c++;
				b_lvl <= (e == 0) ? 3'h1 << (k % 3) : 3'h0;
				idle(6);
				if (k == 2 || k == e)
					e_b = c;
				chk("cap_b", compare_b_value, 16'(e_b));
			end
		end
		chk("cnt_run", counter_value, 16'(c));
		for (int p = 0; p < 2; p++) begin
			wr_run(1'h0);
			period_compare_value <= 3'(p);
			wr_run(1'h1);
			top = p ? 127 : 1023;
			tk(top);
			chk("top", counter_value, 16'(top));
			n_fp = 0;
			tk(1);
			chk("wrap", counter_value, 10'h000);
			chk("flag_p", n_fp, 16'h0001);
		end
		wr_run(1'h0);
		pin_a_enable <= 1'h1;
		pin_b_enable <= 1'h1;
		cfg(ETPC_MODE_PULSE, ETPC_IO_SINGLE, ETPC_IO_SINGLE);
		wr_cc(1'h0, 10'h014);
		wr_cc(1'h1, 10'h008);
		n_fa = 0;
		n_fb = 0;
		wr_run(1'h1);
		chk("pin_a_on", timer_pin_a_out, 1'h1);
		tk(9);
		chk("flag_b", n_fb, 16'h0001);
		chk("pin_b_on", timer_pin_b_out, 3'h7);
		tk(12);
		chk("flag_a", n_fa, 16'h0001);
		chk("run_clr", counter_run_bit, 1'h0);
		chk("off", {timer_pin_a_out, timer_pin_b_out}, 4'h0);
		external_trigger_pin <= 1'h1;
		idle(8);
		chk("trig_run", counter_run_bit, 1'h1);
		chk("restart", counter_value, 10'h000);
		wr_run(1'h0);
		chk("pin_a_off", timer_pin_a_out, 1'h0);
		trigger_falling <= 1'h1;
		external_trigger_pin <= 1'h0;
		idle(8);
		chk("trig_fall", counter_run_bit, 1'h1);
		for (int s = 0; s < 2; s++) begin
			wr_run(1'h0);
			pin_a_enable <= !s[0];
			counter_clear_select <= s[0];
			pwm_alignment_field <= ETPC_ALIGN_CENTRE;
			cfg(ETPC_MODE_PULSE, ETPC_IO_FORCE_LOW, ETPC_IO_PWM);
			wr_cc(1'h0, 10'h00A);
			top = s ? 10 : 128;
			wr_run(1'h1);
			n_fp = 0;
			tk(top);
			chk("b_duty", timer_pin_b_out, 3'h7);
			chk("oe", pin_oe, s ? 4'h1 : 4'h9);
			tk(top);
			chk("cen_zero", counter_value, 10'h000);
			chk("cen_flag", n_fp, 16'h0001);
			chk("forced", timer_pin_a_out, 1'h0);
		end
		stop_test();
	end
endmodule

`default_nettype wire
